// >>> counter_params.svh
// Constants for the presettable four-bit synchronous counter.
`ifndef COUNTER_PARAMS_SVH
`define COUNTER_PARAMS_SVH

`define CNT_WIDTH       4
`define CNT_ZERO        4'h0
`define CNT_ONE         4'h1
`define CNT_RESET_VAL   4'h0
`define CNT_DEC_MAX     4'h9
`define CNT_BIN_MAX     4'hF
`define CNT_DEC_REENTRY 4'h4
`define CNT_RECOVERY    2'h2

`endif

// >>> counter_pkg.sv
// Types shared by the counter modules.
package counter_pkg;

  typedef logic [3:0] count_t;

  typedef enum logic [1:0] {
    MODE_CLEAR = 2'b00,
    MODE_LOAD  = 2'b01,
    MODE_COUNT = 2'b10,
    MODE_HOLD  = 2'b11
  } mode_t;

endpackage

// >>> counter_if.sv
// Internal carrier between the counter top and its helper modules.
`timescale 1ns/1ps
`default_nettype none

interface counter_if;
  import counter_pkg::*;

  count_t state;
  count_t preload;
  count_t nxt;
  logic   clear_req;
  logic   parallel_load_n;
  logic   count_enable_parallel;
  logic   count_enable_trickle;
  logic   terminal_count;
  mode_t  mode;

  modport top (
    output state, preload, clear_req, parallel_load_n,
    output count_enable_parallel, count_enable_trickle,
    input  nxt, mode, terminal_count
  );

  modport route (
    input  state, preload, clear_req, parallel_load_n,
    input  count_enable_parallel, count_enable_trickle,
    output nxt, mode
  );

  modport decode (
    input  state, count_enable_trickle,
    output terminal_count
  );
endinterface

`default_nettype wire

// >>> count_route.sv
// Next-value routing network feeding the four counter flip-flops.
`timescale 1ns/1ps
`default_nettype none
`include "counter_params.svh"

module count_route #(
  parameter bit DECADE = 1'b1
) (
  counter_if.route bus
);
  import counter_pkg::*;

  count_t inc_val;

  always_comb begin
    if (bus.clear_req) begin
      bus.mode = MODE_CLEAR;
    end else if (!bus.parallel_load_n) begin
      bus.mode = MODE_LOAD;
    end else if (bus.count_enable_parallel && bus.count_enable_trickle) begin
      bus.mode = MODE_COUNT;
    end else begin
      bus.mode = MODE_HOLD;
    end
  end

  // Odd illegal codes jump straight back to four, so recovery takes at most two counts.
  always_comb begin
    if (!DECADE) begin
      inc_val = bus.state + `CNT_ONE;
    end else if (bus.state == `CNT_DEC_MAX) begin
      inc_val = `CNT_ZERO;
    end else if (bus.state > `CNT_DEC_MAX) begin
      inc_val = bus.state[0] ? `CNT_DEC_REENTRY : bus.state + `CNT_ONE;
    end else begin
      inc_val = bus.state + `CNT_ONE;
    end
  end

  always_comb begin
    case (bus.mode)
      MODE_CLEAR: begin
        bus.nxt = `CNT_ZERO;
      end
      MODE_LOAD: begin
        bus.nxt = bus.preload;
      end
      MODE_COUNT: begin
        bus.nxt = inc_val;
      end
      MODE_HOLD: begin
        bus.nxt = bus.state;
      end
      default: begin
        bus.nxt = bus.state;
      end
    endcase
  end

endmodule // count_route

`default_nettype wire

// >>> count_decode.sv
// Fully decoded terminal-count output.
`timescale 1ns/1ps
`default_nettype none
`include "counter_params.svh"

module count_decode #(
  parameter bit DECADE = 1'b1
) (
  counter_if.decode bus
);
  import counter_pkg::*;

  count_t max_val;

  assign max_val = DECADE ? `CNT_DEC_MAX : `CNT_BIN_MAX;

  // Exact compare on all four bits, so illegal codes never decode.
  assign bus.terminal_count = bus.count_enable_trickle &&
                              (bus.state == max_val);

endmodule // count_decode

`default_nettype wire

// >>> sync_counter.sv
// Presettable four-bit synchronous counter, decade or binary variant.
//
// Summary of operation
// R1: Count state is four edge-triggered flops fed by a routing network.
// R2: Count outputs change only on rising clock edge, except asynchronous clear; terminal count also follows trickle enable directly.
// R3: No timing restrictions on controls beyond set-up before the edge.
// R4: Load low copies preset inputs at the edge, enables ignored.
// R5: Increment only when load high, both enables high, clear inactive.
// R6: Load high with either enable low holds the count.
// R7: Either enable alone inhibits counting; enable is AND of both.
// R8: Terminal count high when trickle enable high and count at maximum.
// R9: Terminal count decodes exactly one counter state.
// R10: Decade variant counts zero to nine in BCD order.
// R11: Decade variant counting from nine goes to zero.
// R12: Decade variant loads any value but counting never passes nine.
// R13: Decade variant recovers from ten..fifteen within two counting edges.
// R14: Decade illegal states never assert terminal count.
// R15: Binary variant counts modulo sixteen, fifteen wraps to zero.
// R16: Asynchronous variant clear low forces outputs low immediately.
// R17: Synchronous variant clear low zeroes the count at the edge only.
// R18: Edge priority is clear, then load, then count, then hold.
// R19: Asynchronous clear ignores the clock and overrides every control.
// R20: Four variants: decade or binary, with async or sync clear.
// R21: Modulus and clear style are elaboration-time parameters.
`timescale 1ns/1ps
`default_nettype none
`include "counter_params.svh"

module sync_counter #(
  parameter bit DECADE      = 1'b1,
  parameter bit ASYNC_CLEAR = 1'b1
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  // Mode controls
  input  wire logic                parallel_load_n_i,
  input  wire logic                count_enable_parallel_i,
  input  wire logic                count_enable_trickle_i,
  // Clears
  input  wire logic                async_clear_n_i,
  input  wire logic                edge_clear_n_i,
  // Preset data
  input  wire counter_pkg::count_t preload_in_i,
  // Results
  output var  counter_pkg::count_t count_out_o,
  output logic                     terminal_count_o
);
  import counter_pkg::*;

  count_t    count_r;
  count_t    count_nxt;
  logic      clear_in;
  logic      cnt_en;
  count_t    max_val;
  counter_if bus ();

  assign max_val  = DECADE ? `CNT_DEC_MAX : `CNT_BIN_MAX;
  // The edge clear only exists in the synchronous-clear variant.
  assign clear_in = !ASYNC_CLEAR && !edge_clear_n_i; // R17 R20 R21
  assign cnt_en   = parallel_load_n_i && count_enable_parallel_i &&
                    count_enable_trickle_i; // R5 R7

  assign bus.state                 = count_r;
  assign bus.preload               = preload_in_i;
  assign bus.clear_req             = clear_in;
  assign bus.parallel_load_n       = parallel_load_n_i;
  assign bus.count_enable_parallel = count_enable_parallel_i;
  assign bus.count_enable_trickle  = count_enable_trickle_i;
  assign count_nxt                 = bus.nxt;

  // Controls come from logic on the same clock and are sampled once. R3
  count_route #(
    .DECADE (DECADE)
  ) u_route (
    .bus (bus.route)
  ); // R1 R4 R5 R6 R10 R11 R12 R13 R15 R18

  count_decode #(
    .DECADE (DECADE)
  ) u_decode (
    .bus (bus.decode)
  ); // R8 R9 R14

  generate
    if (ASYNC_CLEAR) begin : g_async
      // Clear acts on the flops directly, without waiting for an edge.
      always_ff @(posedge clk_i or negedge async_clear_n_i) begin
        if (!async_clear_n_i) begin
          count_r <= `CNT_ZERO; // R16 R19
        end else if (sys_rst_i) begin
          count_r <= `CNT_RESET_VAL;
        end else begin
          count_r <= count_nxt; // R2
        end
      end
    end else begin : g_sync
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          count_r <= `CNT_RESET_VAL;
        end else begin
          count_r <= count_nxt; // R2 R17
        end
      end
    end
  endgenerate

  assign count_out_o      = count_r;
  assign terminal_count_o = bus.terminal_count; // R8

  AST_LOAD_COPIES: assert property ( // R4
    @(posedge clk_i) disable iff (sys_rst_i || !async_clear_n_i)
    (!clear_in && !parallel_load_n_i)
    |=> (count_out_o == $past(preload_in_i))
  ) else $error("Load did not copy the preset inputs.");

  AST_COUNT_STEP: assert property ( // R5
    @(posedge clk_i) disable iff (sys_rst_i || !async_clear_n_i)
    (!clear_in && cnt_en && count_out_o < max_val)
    |=> (count_out_o == $past(count_out_o) + `CNT_ONE)
  ) else $error("Enabled count did not advance by one.");

  AST_HOLD_ON_INHIBIT: assert property ( // R6
    @(posedge clk_i) disable iff (sys_rst_i || !async_clear_n_i)
    (!clear_in && parallel_load_n_i &&
     (!count_enable_parallel_i || !count_enable_trickle_i))
    |=> $stable(count_out_o)
  ) else $error("Count changed while an enable was low.");

  AST_TRICKLE_INHIBIT: assert property ( // R7
    @(posedge clk_i) disable iff (sys_rst_i || !async_clear_n_i)
    (!clear_in && parallel_load_n_i && count_enable_parallel_i &&
     !count_enable_trickle_i) [*2]
    |=> (count_out_o == $past(count_out_o, 2))
  ) else $error("Trickle enable low alone failed to inhibit.");

  AST_TC_AT_MAX: assert property ( // R8
    @(posedge clk_i) disable iff (sys_rst_i)
    (count_enable_trickle_i && count_out_o == max_val)
    |-> terminal_count_o
  ) else $error("Terminal count missing at the maximum state.");

  AST_TC_ONE_STATE: assert property ( // R9
    @(posedge clk_i) disable iff (sys_rst_i)
    terminal_count_o
    |-> (count_out_o == max_val && count_enable_trickle_i)
  ) else $error("Terminal count high outside the maximum state.");

  AST_DEC_WRAP: assert property ( // R11
    @(posedge clk_i) disable iff (sys_rst_i || !async_clear_n_i)
    (DECADE && !clear_in && cnt_en && count_out_o == `CNT_DEC_MAX)
    |=> (count_out_o == `CNT_ZERO)
  ) else $error("Decade count from nine did not return to zero.");

  AST_DEC_STAYS_LEGAL: assert property ( // R10 R12
    @(posedge clk_i) disable iff (sys_rst_i || !async_clear_n_i)
    (DECADE && !clear_in && parallel_load_n_i &&
     count_out_o <= `CNT_DEC_MAX)
    |=> (count_out_o <= `CNT_DEC_MAX)
  ) else $error("Decade count moved beyond nine.");

  AST_DEC_REENTRY: assert property ( // R13
    @(posedge clk_i) disable iff (sys_rst_i || !async_clear_n_i)
    (DECADE && !clear_in && cnt_en && count_out_o > `CNT_DEC_MAX)
    ##1 (!clear_in && cnt_en)
    |=> (count_out_o <= `CNT_DEC_MAX)
  ) else $error("Decade count failed to recover within two counts.");

  AST_DEC_NO_ILLEGAL_TC: assert property ( // R14
    @(posedge clk_i) disable iff (sys_rst_i)
    (DECADE && count_out_o > `CNT_DEC_MAX) |-> !terminal_count_o
  ) else $error("Illegal decade state raised terminal count.");

  AST_BIN_WRAP: assert property ( // R15
    @(posedge clk_i) disable iff (sys_rst_i || !async_clear_n_i)
    (!DECADE && !clear_in && cnt_en && count_out_o == `CNT_BIN_MAX)
    |=> (count_out_o == `CNT_ZERO)
  ) else $error("Binary count from fifteen did not wrap to zero.");

  AST_ASYNC_CLEAR: assert property ( // R16 R19
    @(posedge clk_i) disable iff (sys_rst_i)
    (ASYNC_CLEAR && !async_clear_n_i)
    |-> (count_out_o == `CNT_ZERO && bus.mode != MODE_CLEAR)
  ) else $error("Asynchronous clear did not hold the count at zero.");

  AST_SYNC_CLEAR: assert property ( // R17 R18
    @(posedge clk_i) disable iff (sys_rst_i)
    (!ASYNC_CLEAR && !edge_clear_n_i)
    |=> (count_out_o == `CNT_ZERO)
  ) else $error("Edge clear did not zero the count.");

  AST_SYNC_CLEAR_EDGE_ONLY: assert property ( // R17 R2
    @(posedge clk_i) disable iff (sys_rst_i)
    (!ASYNC_CLEAR && edge_clear_n_i && parallel_load_n_i &&
     !count_enable_trickle_i)
    |=> $stable(count_out_o)
  ) else $error("Count changed without a clock-edge cause.");

  AST_MODE_PRIORITY: assert property ( // R18
    @(posedge clk_i) disable iff (sys_rst_i)
    (clear_in |-> bus.mode == MODE_CLEAR) and
    ((!clear_in && !parallel_load_n_i) |-> bus.mode == MODE_LOAD)
  ) else $error("Mode priority order violated.");

  // Counting edges spent above nine since the last load. A hold keeps the
  // figure, since recovery is only promised over counting edges.
  logic [1:0] illegal_run_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || (ASYNC_CLEAR && !async_clear_n_i)) begin
      illegal_run_r <= 2'h0;
    end else if (clear_in || !parallel_load_n_i) begin
      illegal_run_r <= 2'h0;
    end else if (!DECADE || count_out_o <= `CNT_DEC_MAX) begin
      illegal_run_r <= 2'h0;
    end else if (cnt_en && illegal_run_r != `CNT_RECOVERY) begin
      illegal_run_r <= illegal_run_r + 2'h1;
    end
  end

  AST_DEC_RECOVERY_BOUND: assert property ( // R13
    @(posedge clk_i) disable iff (sys_rst_i)
    (DECADE && count_out_o > `CNT_DEC_MAX)
    |-> (illegal_run_r < `CNT_RECOVERY)
  ) else $error("Decade count stayed illegal for two counting edges.");

  AST_PARALLEL_INHIBIT: assert property ( // R7
    @(posedge clk_i) disable iff (sys_rst_i || !async_clear_n_i)
    (!clear_in && parallel_load_n_i && !count_enable_parallel_i &&
     count_enable_trickle_i) [*2]
    |=> (count_out_o == $past(count_out_o, 2))
  ) else $error("Parallel enable low alone failed to inhibit.");

  AST_TC_NEEDS_TRICKLE: assert property ( // R8
    @(posedge clk_i) disable iff (sys_rst_i)
    !count_enable_trickle_i |-> !terminal_count_o
  ) else $error("Terminal count high with trickle enable low.");

  AST_TC_OFF_ELSEWHERE: assert property ( // R9
    @(posedge clk_i) disable iff (sys_rst_i)
    (count_out_o != max_val) |-> !terminal_count_o
  ) else $error("Terminal count decoded a second state.");

  AST_BIN_STEP: assert property ( // R15
    @(posedge clk_i) disable iff (sys_rst_i || !async_clear_n_i)
    (!DECADE && !clear_in && cnt_en)
    |=> (count_out_o == count_t'($past(count_out_o) + `CNT_ONE))
  ) else $error("Binary count did not step modulo sixteen.");

  AST_LOAD_OVER_COUNT: assert property ( // R4 R18
    @(posedge clk_i) disable iff (sys_rst_i || !async_clear_n_i)
    (!clear_in && !parallel_load_n_i && count_enable_parallel_i &&
     count_enable_trickle_i)
    |=> (count_out_o == $past(preload_in_i))
  ) else $error("Count won over load.");

  AST_ASYNC_IGNORES_EDGE_CLEAR: assert property ( // R20
    @(posedge clk_i) disable iff (sys_rst_i || !async_clear_n_i)
    (ASYNC_CLEAR && !edge_clear_n_i && !parallel_load_n_i)
    |=> (count_out_o == $past(preload_in_i))
  ) else $error("Edge clear acted in the asynchronous variant.");

  AST_SYNC_IGNORES_ASYNC_CLEAR: assert property ( // R20
    @(posedge clk_i) disable iff (sys_rst_i)
    (!ASYNC_CLEAR && !async_clear_n_i && edge_clear_n_i &&
     !parallel_load_n_i)
    |=> (count_out_o == $past(preload_in_i))
  ) else $error("Master clear acted in the synchronous variant.");

  AST_MODE_COUNT_ONLY: assert property ( // R5
    @(posedge clk_i) disable iff (sys_rst_i)
    (bus.mode == MODE_COUNT) |-> (!clear_in && cnt_en)
  ) else $error("Count mode chosen without every enable.");

  AST_MODE_HOLD_ONLY: assert property ( // R6
    @(posedge clk_i) disable iff (sys_rst_i)
    (bus.mode == MODE_HOLD)
    |-> (!clear_in && parallel_load_n_i && !cnt_en)
  ) else $error("Hold mode chosen while a load or count was due.");

  AST_RESET_ZEROES: assert property (
    @(posedge clk_i)
    sys_rst_i |=> (count_out_o == `CNT_RESET_VAL)
  ) else $error("Reset did not zero the count.");

  AST_FLOPS_FOLLOW_ROUTE: assert property ( // R1
    @(posedge clk_i) disable iff (sys_rst_i || !async_clear_n_i)
    !sys_rst_i |=> (count_out_o == $past(bus.nxt))
  ) else $error("Counter flops did not take the routed value.");

  AST_EDGE_CLEAR_OVER_COUNT: assert property ( // R18
    @(posedge clk_i) disable iff (sys_rst_i)
    (!ASYNC_CLEAR && !edge_clear_n_i && cnt_en)
    |=> (count_out_o == `CNT_ZERO)
  ) else $error("Count won over the edge clear.");

endmodule // sync_counter

`default_nettype wire

// >>> cascade_stage.sv
// Behavioural next decade stage fed by the first stage's terminal count.
`timescale 1ns/1ps
`default_nettype none

module cascade_stage (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Enables from the first stage
  input  wire logic       enable_i,
  input  wire logic       carry_i,
  // Result
  output logic      [3:0] digit_o
);
  logic [3:0] digit_r;

  // The carry joins the shared parallel enable, so no gate sits between.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      digit_r <= 4'h0;
    end else if (enable_i && carry_i) begin
      digit_r <= (digit_r == 4'h9) ? 4'h0 : digit_r + 4'h1;
    end
  end

  assign digit_o = digit_r;
endmodule // cascade_stage

`default_nettype wire

// >>> test_presettable_sync_counter_4bit.sv
// Testbench for the decade and binary counter variants.
`timescale 1ns/1ps
`default_nettype none

module test_presettable_sync_counter_4bit;
  import counter_pkg::*;

  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [2:0]  ctrl = 3'h0;
  logic        aclr_n = 1'b1;
  logic        eclr_n = 1'b1;
  count_t      pin = 4'h0;
  count_t      cnt_d;
  count_t      cnt_b;
  logic        tc_d;
  logic        tc_b;
  logic [3:0]  stage;
  logic [15:0] rows [14];
  int          failures = 0;
  int          samples_checked = 0;

  always #10 clk_i = ~clk_i;

  sync_counter #(.DECADE(1'b1), .ASYNC_CLEAR(1'b1)) u_sync_counter (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .parallel_load_n_i(ctrl[2]),
    .count_enable_parallel_i(ctrl[1]), .count_enable_trickle_i(ctrl[0]),
    .async_clear_n_i(aclr_n), .edge_clear_n_i(eclr_n),
    .preload_in_i(pin), .count_out_o(cnt_d), .terminal_count_o(tc_d));

  sync_counter #(.DECADE(1'b0), .ASYNC_CLEAR(1'b0)) u_sync_counter_bin (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .parallel_load_n_i(ctrl[2]),
    .count_enable_parallel_i(ctrl[1]), .count_enable_trickle_i(ctrl[0]),
    .async_clear_n_i(aclr_n), .edge_clear_n_i(eclr_n),
    .preload_in_i(pin), .count_out_o(cnt_b), .terminal_count_o(tc_b));

  cascade_stage u_cascade_stage (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .enable_i(ctrl[1]),
    .carry_i(tc_d), .digit_o(stage));

  task automatic chk_cnt(input count_t got, input count_t exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    // Row layout: load_n, parallel and trickle enable, preset,
    // then the decade and the binary count after the edge.
    rows = '{16'h0888, 16'h7099, 16'h700A, 16'h500A, 16'h600A,
             16'h3FFF, 16'h7040, 16'h3AAA, 16'h70BB, 16'h704C,
             16'h3CCC, 16'h70DD, 16'h704E, 16'h2999};
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk_cnt(cnt_d, 4'h0);
    chk_cnt(cnt_b, 4'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      ctrl = rows[i][14:12];
      pin = rows[i][11:8];
      @(negedge clk_i);
      chk_cnt(cnt_d, rows[i][7:4]);
      chk_cnt(cnt_b, rows[i][3:0]);
      chk_flag(tc_d, ctrl[0] && rows[i][7:4] == 4'h9);
      chk_flag(tc_b, ctrl[0] && rows[i][3:0] == 4'hF);
    end
    $display("test rows done");
    ctrl = 3'h7;
    aclr_n = 1'b0;
    #1;
    chk_cnt(cnt_d, 4'h0);
    @(negedge clk_i);
    ctrl = 3'h3;
    pin = 4'h7;
    @(negedge clk_i);
    chk_cnt(cnt_d, 4'h0);
    aclr_n = 1'b1;
    @(negedge clk_i);
    chk_cnt(cnt_d, 4'h7);
    chk_cnt(cnt_b, 4'h7);
    $display("test async clear done");
    eclr_n = 1'b0;
    pin = 4'h5;
    #1;
    chk_cnt(cnt_b, 4'h7);
    @(negedge clk_i);
    chk_cnt(cnt_b, 4'h0);
    chk_cnt(cnt_d, 4'h5);
    eclr_n = 1'b1;
    $display("test edge clear done");
    sys_rst_i = 1'b1;
    pin = 4'h3;
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    ctrl = 3'h7;
    chk_cnt(cnt_d, 4'h0);
    chk_cnt(cnt_b, 4'h0);
    for (int i = 1; i <= 20; i++) begin
      @(negedge clk_i);
      chk_cnt(cnt_d, count_t'(i % 10));
      chk_cnt(cnt_b, count_t'(i % 16));
      chk_flag(tc_d, i % 10 == 9);
      chk_flag(tc_b, i % 16 == 15);
    end
    // Two passes through nine must carry twice into the next stage.
    chk_cnt(stage, 4'h2);
    $display("test count run done");
    ctrl = 3'h6;
    repeat (2) begin
      @(negedge clk_i);
      chk_cnt(cnt_d, 4'h0);
      chk_cnt(cnt_b, 4'h4);
    end
    ctrl = 3'h5;
    repeat (2) begin
      @(negedge clk_i);
      chk_cnt(cnt_d, 4'h0);
      chk_cnt(cnt_b, 4'h4);
    end
    eclr_n = 1'b0;
    ctrl = 3'h7;
    @(negedge clk_i);
    chk_cnt(cnt_b, 4'h0);
    chk_cnt(cnt_d, 4'h1);
    eclr_n = 1'b1;
    @(negedge clk_i);
    chk_cnt(cnt_b, 4'h1);
    chk_cnt(cnt_d, 4'h2);
    $display("test inhibit done");
    conclude();
  end
endmodule // test_presettable_sync_counter_4bit

`default_nettype wire
